// ===== rtl/edge_counter.sv
`default_nettype none
module edge_counter #(
  parameter int CW = pmcs_pkg::CNT_W
) (
  input wire logic i_sys_clk,             // System clock
  input wire logic i_reset,               // Async reset, active high
  input wire logic i_clear,               // Restart count
  input wire logic i_step,                // One counted event
  input wire logic [CW-1:0] i_target,     // Events needed
  output logic o_done                     // Target reached, held until clear
);
  import pmcs_pkg::*;

  typedef struct packed {
    logic [CW-1:0] count;
    logic done;
  } cnt_s;

  cnt_s s;
  cnt_s next_s;
  logic [CW-1:0] bumped;

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (CW < 2) begin : g_bad_width
    $error("edge_counter width too small");
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb begin
    next_s = s;
    bumped = s.count + {{(CW-1){1'b0}}, 1'b1};
    if (i_clear) begin
      next_s = '0;
    end else if (!s.done && i_step) begin
      next_s.count = bumped;
      next_s.done = (bumped >= i_target);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_done = s.done;

endmodule : edge_counter
`default_nettype wire

// ===== rtl/osc_pin_sync.sv
`default_nettype none
module osc_pin_sync (
  input wire logic i_sys_clk,                 // System clock
  input wire logic i_reset,                   // Async reset, active high
  input wire pmcs_pkg::osc_pins_s i_pins,     // Raw oscillator levels
  output pmcs_pkg::osc_pins_s o_pins          // Two-flop synchronised levels
);
  import pmcs_pkg::*;

  pin_sync_s s;
  pin_sync_s next_s;

  // ==========================================================================
  // Two-flop synchroniser
  // ==========================================================================
  always_comb begin
    next_s.meta = i_pins;
    next_s.sync = s.meta;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pins = s.sync;

endmodule : osc_pin_sync
`default_nettype wire

// ===== rtl/pmcs_pkg.sv
`default_nettype none
package pmcs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int OST_CYCLES = 1024;
  localparam int SW_OLD_EDGES = 2;
  localparam int SW_NEW_EDGES = 3;
  localparam int CNT_W = 11;
  localparam int CPU_READY_DELAY_NS_DEFAULT = 100;

  // ==========================================================================
  // Clock sources, coded as the select field
  // ==========================================================================
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_SEC = 2'h1,
    SRC_PRI = 2'h2,
    SRC_RC = 2'h3
  } src_e;

  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_PRI = 2'h2;
  localparam logic [1:0] SEL_RC = 2'h3;

  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_RUN = 8'h02,
    ST_SW_OLD = 8'h04,
    ST_SW_NEW = 8'h08,
    ST_IDLE = 8'h10,
    ST_SLEEP = 8'h20,
    ST_WAKE = 8'h40,
    ST_CPU_DLY = 8'h80
  } pm_state_e;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic pri;
    logic sec;
    logic rc;
  } osc_pins_s;

  typedef struct packed {
    osc_pins_s meta;
    osc_pins_s sync;
  } pin_sync_s;

  typedef struct packed {
    logic [1:0] clock_source_select;
    logic idle_select_bit;
    logic secondary_osc_enable;
    logic wdt_enabled;
    logic fscm_enabled;
    logic two_speed_enabled;
    logic pri_is_crystal;
    logic zero_sel_primary;
  } mode_ctrl_s;

  typedef struct packed {
    src_e mux_sel;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pri_osc_run;
    logic sec_osc_run;
    logic rc_osc_run;
  } clk_ctrl_s;

  typedef struct packed {
    logic primary_clock_active_flag;
    logic secondary_clock_active_flag;
  } status_s;

  typedef struct packed {
    pm_state_e state;
    src_e target;
    clk_ctrl_s clk;
    status_s status;
    logic idle_pend;
    logic wake_pend;
    logic rc_interim;
    osc_pins_s edge_prev;
  } ctrl_s;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam clk_ctrl_s CLK_RESET = '{mux_sel: SRC_PRI, cpu_clk_en: 1'b1, periph_clk_en: 1'b1,
                                      pri_osc_run: 1'b1, sec_osc_run: 1'b0, rc_osc_run: 1'b0};
  localparam status_s STATUS_RESET = '{primary_clock_active_flag: 1'b1, secondary_clock_active_flag: 1'b0};

endpackage : pmcs_pkg
`default_nettype wire

// ===== rtl/power_mode_clock_switch_control.sv
// Summary of operation
// RQ1 - Source switch takes two old-clock edges plus three to four new-clock edges.
// RQ2 - Primary and secondary active flags report source; neither set means internal RC.
// RQ3 - Each power-down uses idle select as it stands at that moment.
// RQ4 - Reset starts in primary run, primary flag set, unless two-speed start-up.
// RQ5 - Select 01 moves to secondary, stops primary, sets secondary flag, clears primary.
// RQ6 - Select 01 with secondary oscillator disabled does not enter secondary run.
// RQ7 - Secondary enabled but not oscillating holds clocks off until it starts.
// RQ8 - Back to primary: stay on secondary until primary ready, then swap flags.
// RQ9 - Select 11 moves to internal RC, stops primary, clears primary flag.
// RQ10 - Internal back to primary: stay on RC until primary ready, then set flag.
// RQ11 - RC keeps running after primary switch when watchdog or monitor enabled.
// RQ12 - Switches and wake-ups never alter idle select or source select.
// RQ13 - Power-down with idle clear sleeps, stops oscillator, clears both flags.
// RQ14 - In sleep or idle, RC runs for watchdog, secondary runs if enabled.
// RQ15 - Sleep wake waits for selected source; RC meanwhile with two-speed or monitor.
// RQ16 - Power-down with idle set stops CPU clock, peripherals run, flags untouched.
// RQ17 - Idle exits on interrupt, watchdog or reset; CPU resumes after ready delay.
// RQ18 - Watchdog time-out in sleep or idle wakes into selected run mode.
// RQ19 - Primary idle keeps primary running and its flag set.
// RQ20 - Secondary idle entry shuts primary, swaps flags; wake runs on secondary.
// RQ21 - Power-down for secondary idle with secondary disabled is ignored.
// RQ22 - Source select: 11 internal, 10 primary, 01 secondary.
// RQ23 - Crystal primary counts as ready after 1024 oscillator cycles.
// RQ24 - Switches are glitch-free: gates close before the mux moves; two-speed start-up moves the mux to RC with both gates open.
`default_nettype none
module power_mode_clock_switch_control #(
  parameter int CPU_READY_DELAY_NS = pmcs_pkg::CPU_READY_DELAY_NS_DEFAULT
) (
  input wire logic i_sys_clk,                      // System clock, 200 MHz
  input wire logic i_reset,                        // Async reset, active high
  input wire pmcs_pkg::mode_ctrl_s i_mode,         // Control bits from registers
  input wire logic i_power_down_exec,              // Power-down instruction, one-cycle pulse
  input wire logic i_wake_interrupt,               // Enabled interrupt flag raised
  input wire logic i_wdt_timeout,                  // Watchdog time-out event
  input wire pmcs_pkg::osc_pins_s i_osc,           // Raw oscillator outputs
  output pmcs_pkg::clk_ctrl_s o_clk,               // Mux, gates and oscillator enables
  output pmcs_pkg::status_s o_status               // Clock source active flags
);
  import pmcs_pkg::*;

  // ==========================================================================
  // Derived counts
  // ==========================================================================
  localparam int CSD_RAW = (CPU_READY_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int CSD_CYCLES = (CSD_RAW < 1) ? 1 : CSD_RAW;
  localparam logic [CNT_W-1:0] CSD_TARGET = CNT_W'(CSD_CYCLES);
  localparam logic [CNT_W-1:0] OST_TARGET = CNT_W'(OST_CYCLES);
  localparam logic [CNT_W-1:0] OLD_TARGET = CNT_W'(SW_OLD_EDGES);
  localparam logic [CNT_W-1:0] NEW_TARGET = CNT_W'(SW_NEW_EDGES);

  if (CSD_CYCLES >= (1 << CNT_W)) begin : g_bad_csd
    $error("cpu ready delay does not fit the counter");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Select 00 maps by the zero-select input
  function automatic src_e decode_sel(input logic [1:0] sel, input logic zero_pri);
    case (sel)
      SEL_SEC: decode_sel = SRC_SEC;  // RQ22
      SEL_PRI: decode_sel = SRC_PRI;  // RQ22
      SEL_RC: decode_sel = SRC_RC;  // RQ22
      default: decode_sel = zero_pri ? SRC_PRI : SRC_RC;
    endcase
  endfunction : decode_sel

  // Rising edge of whichever source is named
  function automatic logic edge_of(input src_e src, input osc_pins_s edges);
    case (src)
      SRC_PRI: edge_of = edges.pri;
      SRC_SEC: edge_of = edges.sec;
      SRC_RC: edge_of = edges.rc;
      default: edge_of = 1'b0;
    endcase
  endfunction : edge_of

  // ==========================================================================
  // State and wiring
  // ==========================================================================
  ctrl_s s;
  ctrl_s next_s;
  osc_pins_s osc_lvl;
  osc_pins_s osc_edge;

  // Decode of the select field and readiness
  src_e desired;
  logic sec_blocked;
  logic pri_ready;
  logic target_ready;
  logic go_switch;

  // Shared counter hookup
  logic ost_done;
  logic seq_done;
  logic seq_clear;
  logic seq_step;
  logic [CNT_W-1:0] seq_target;

  // Interrupt or watchdog, both wake alike
  logic wake_event;

  osc_pin_sync u_osc_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_pins(i_osc),
    .o_pins(osc_lvl)
  );

  // Oscillator start-up timer; held clear while primary is off
  edge_counter #(.CW(CNT_W)) u_ost (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clear(!s.clk.pri_osc_run),
    .i_step(osc_edge.pri),
    .i_target(OST_TARGET),
    .o_done(ost_done)
  );

  // Shared sequencer: old-edge, new-edge and CPU ready delay counts
  edge_counter #(.CW(CNT_W)) u_seq (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clear(seq_clear),
    .i_step(seq_step),
    .i_target(seq_target),
    .o_done(seq_done)
  );

  assign osc_edge = osc_lvl & ~s.edge_prev;
  assign desired = decode_sel(i_mode.clock_source_select, i_mode.zero_sel_primary);
  assign sec_blocked = (desired == SRC_SEC) && !i_mode.secondary_osc_enable;  // RQ6
  assign pri_ready = s.clk.pri_osc_run && (ost_done || !i_mode.pri_is_crystal);  // RQ23
  assign wake_event = i_wake_interrupt || i_wdt_timeout;  // RQ17 RQ18
  assign go_switch = (desired != s.clk.mux_sel) && !sec_blocked && ((desired != SRC_PRI) || pri_ready);
  assign seq_clear = (next_s.state != s.state);

  // Readiness of the source being switched to
  always_comb begin
    case (s.target)
      SRC_PRI: target_ready = pri_ready;
      SRC_SEC: target_ready = i_mode.secondary_osc_enable;
      default: target_ready = 1'b1;
    endcase
  end

  // Counted event and target per sequencer state
  always_comb begin
    case (s.state)
      ST_SW_OLD: begin
        seq_step = edge_of(s.clk.mux_sel, osc_edge);
        seq_target = OLD_TARGET;
      end
      ST_SW_NEW: begin
        seq_step = edge_of(s.clk.mux_sel, osc_edge);
        seq_target = NEW_TARGET;
      end
      ST_CPU_DLY: begin
        seq_step = 1'b1;
        seq_target = CSD_TARGET;
      end
      default: begin
        seq_step = 1'b0;
        seq_target = OLD_TARGET;
      end
    endcase
  end

  // ==========================================================================
  // Power-mode sequencer
  // ==========================================================================
  // The select and idle bits are inputs only; this block never writes them. RQ12
  always_comb begin
    next_s = s;
    next_s.edge_prev = osc_lvl;
    next_s.clk.sec_osc_run = i_mode.secondary_osc_enable;  // RQ14
    case (s.state)
      ST_INIT: begin
        next_s.state = ST_RUN;
        if (i_mode.two_speed_enabled) begin
          next_s.clk.mux_sel = SRC_RC;
          next_s.status.primary_clock_active_flag = 1'b0;
        end
      end

      // Run: both gates open
      ST_RUN: begin
        next_s.clk.cpu_clk_en = 1'b1;
        next_s.clk.periph_clk_en = 1'b1;

        // Primary starts while we keep running on the current source RQ8 RQ10
        if (desired == SRC_PRI) begin
          next_s.clk.pri_osc_run = 1'b1;
        end

        if (i_power_down_exec && !i_mode.idle_select_bit) begin
          // Sleep needs no switch; gates and primary stop, mux to none RQ3 RQ13
          next_s.state = ST_SLEEP;
          next_s.clk.cpu_clk_en = 1'b0;
          next_s.clk.periph_clk_en = 1'b0;
          next_s.clk.pri_osc_run = 1'b0;
          next_s.clk.mux_sel = SRC_NONE;
          next_s.status = '0;
          next_s.idle_pend = 1'b0;
        end else if (i_power_down_exec && sec_blocked) begin
          next_s.idle_pend = 1'b0;  // RQ21
        end else if (i_power_down_exec && desired == s.clk.mux_sel) begin
          next_s.state = ST_IDLE;  // RQ3 RQ16 RQ19
          next_s.clk.cpu_clk_en = 1'b0;
        end else begin
          if (i_power_down_exec) begin
            next_s.idle_pend = 1'b1;  // RQ20
          end
          if (go_switch) begin
            next_s.target = desired;
            next_s.state = ST_SW_OLD;
          end
        end
      end

      // Switch, old-clock half
      ST_SW_OLD: begin
        // Close the gates on the old clock, then move the mux while quiet RQ1 RQ24
        if (seq_done && (s.clk.cpu_clk_en || s.clk.periph_clk_en)) begin
          next_s.clk.cpu_clk_en = 1'b0;
          next_s.clk.periph_clk_en = 1'b0;
        end else if (seq_done) begin
          next_s.clk.mux_sel = s.target;
          next_s.state = ST_SW_NEW;
        end
      end

      // Switch, new-clock half
      ST_SW_NEW: begin
        // Waits on new-clock edges, so a silent secondary holds clocks off RQ1 RQ7
        if (seq_done) begin
          next_s.status.primary_clock_active_flag = (s.clk.mux_sel == SRC_PRI);  // RQ2 RQ5 RQ8 RQ10
          next_s.status.secondary_clock_active_flag = (s.clk.mux_sel == SRC_SEC);  // RQ2 RQ5 RQ8 RQ20
          next_s.clk.pri_osc_run = (s.clk.mux_sel == SRC_PRI);  // RQ5 RQ9
          next_s.clk.periph_clk_en = 1'b1;
          next_s.rc_interim = 1'b0;
          next_s.idle_pend = 1'b0;

          if (s.wake_pend) begin
            next_s.state = ST_CPU_DLY;
          end else if (s.idle_pend) begin
            next_s.state = ST_IDLE;  // RQ20
          end else begin
            next_s.clk.cpu_clk_en = 1'b1;
            next_s.state = ST_RUN;
          end
        end
      end

      // Idle: peripherals only
      ST_IDLE: begin
        next_s.clk.cpu_clk_en = 1'b0;
        next_s.clk.periph_clk_en = 1'b1;
        if (wake_event) begin
          next_s.state = ST_CPU_DLY;  // RQ17 RQ18
        end
      end

      // CPU ready delay after a wake
      ST_CPU_DLY: begin
        // CPU resumes on the idle source; run state then follows the select RQ17 RQ18
        next_s.clk.periph_clk_en = 1'b1;
        if (seq_done) begin
          next_s.clk.cpu_clk_en = 1'b1;
          next_s.wake_pend = 1'b0;
          next_s.state = ST_RUN;
        end
      end

      // Sleep: all gates shut
      ST_SLEEP: begin
        if (wake_event) begin
          next_s.state = ST_WAKE;  // RQ15 RQ18
          next_s.wake_pend = 1'b1;
          next_s.target = sec_blocked ? SRC_RC : desired;
          next_s.clk.pri_osc_run = (desired == SRC_PRI);

          if (i_mode.two_speed_enabled || i_mode.fscm_enabled) begin
            next_s.rc_interim = 1'b1;  // RQ15
            next_s.clk.mux_sel = SRC_RC;
            next_s.clk.cpu_clk_en = 1'b1;
            next_s.clk.periph_clk_en = 1'b1;
          end
        end
      end

      // Waiting for the woken source
      ST_WAKE: begin
        // Unclocked, or on RC, until the selected source is ready RQ15
        if (target_ready) begin
          if (s.rc_interim && s.target == SRC_RC) begin
            next_s.rc_interim = 1'b0;
            next_s.clk.cpu_clk_en = 1'b0;
            next_s.state = ST_CPU_DLY;
          end else if (s.rc_interim) begin
            next_s.state = ST_SW_OLD;
          end else begin
            next_s.clk.mux_sel = s.target;
            next_s.state = ST_SW_NEW;
          end
        end
      end

      // Illegal codes recover to run
      default: begin
        next_s.state = ST_RUN;
      end
    endcase
    // RC runs while it clocks the device or while watchdog or monitor need it RQ11 RQ14
    next_s.clk.rc_osc_run = (next_s.clk.mux_sel == SRC_RC) || next_s.rc_interim ||
                            i_mode.wdt_enabled || i_mode.fscm_enabled;
  end

  // Reset branch loads constants only
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s.state <= ST_INIT;  // RQ4
      s.target <= SRC_PRI;
      s.clk <= CLK_RESET;  // RQ4
      s.status <= STATUS_RESET;  // RQ4
      s.idle_pend <= 1'b0;
      s.wake_pend <= 1'b0;
      s.rc_interim <= 1'b0;
      s.edge_prev <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops
  assign o_clk = s.clk;
  assign o_status = s.status;

endmodule : power_mode_clock_switch_control
`default_nettype wire

// ===== verif/osc_source_model.sv
`default_nettype none
module osc_source_model
  import pmcs_pkg::*;
#(
  parameter real PRI_HALF_NS = 5.0,
  parameter real SEC_HALF_NS = 20.5,
  parameter real RC_HALF_NS = 16.0
) (
  input wire pmcs_pkg::clk_ctrl_s i_ctrl, // Oscillator enables
  input wire logic i_sec_hold, // Secondary not oscillating yet
  output var pmcs_pkg::osc_pins_s o_pins // Oscillator outputs
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Sources freeze while disabled
  logic pri_lvl = 1'b0;
  logic sec_lvl = 1'b0;
  logic rc_lvl = 1'b0;
  always #(PRI_HALF_NS) if (i_ctrl.pri_osc_run) pri_lvl = ~pri_lvl;
  // Held secondary stays silent, as if still starting
  always #(SEC_HALF_NS) if (i_ctrl.sec_osc_run && !i_sec_hold) sec_lvl = ~sec_lvl;
  always #(RC_HALF_NS) if (i_ctrl.rc_osc_run) rc_lvl = ~rc_lvl;
  assign o_pins = '{pri: pri_lvl, sec: sec_lvl, rc: rc_lvl};
endmodule : osc_source_model
`default_nettype wire

// ===== verif/power_mode_clock_switch_control_sva.sv
`default_nettype none
module power_mode_clock_switch_control_sva
  import pmcs_pkg::*;
#(
  parameter int CPU_READY_DELAY_NS = CPU_READY_DELAY_NS_DEFAULT
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_reset, // Async reset
  input wire pmcs_pkg::mode_ctrl_s i_mode, // Control bits
  input wire logic i_power_down_exec, // Power-down pulse
  input wire logic i_wake_interrupt, // Wake interrupt
  input wire logic i_wdt_timeout, // Watchdog time-out
  input wire pmcs_pkg::osc_pins_s i_osc, // Oscillator levels
  input wire pmcs_pkg::clk_ctrl_s o_clk, // Clock control
  input wire pmcs_pkg::status_s o_status // Source flags
);
  localparam int DLY_MAX = CPU_READY_DELAY_NS / SYS_CLK_PERIOD_NS + 4;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // ==========================================
  // Source flags against the mux
  a_flags_exclusive: assert property (!(o_status.primary_clock_active_flag && o_status.secondary_clock_active_flag))
    else $error("both source flags set");
  a_pri_flag_mux: assert property (o_clk.periph_clk_en && o_status.primary_clock_active_flag &&
    !i_mode.two_speed_enabled |-> o_clk.mux_sel == SRC_PRI) else $error("primary flag without primary mux");
  a_sec_flag_mux: assert property (o_clk.periph_clk_en && o_status.secondary_clock_active_flag |->
    o_clk.mux_sel == SRC_SEC) else $error("secondary flag without secondary mux");
  a_pri_flag_osc: assert property (o_status.primary_clock_active_flag |-> o_clk.pri_osc_run)
    else $error("primary flag with primary stopped");
  a_sec_refused: assert property (!i_mode.secondary_osc_enable && o_clk.mux_sel != SRC_SEC |=>
    o_clk.mux_sel != SRC_SEC) else $error("switched to disabled secondary");
  // ==========================================
  // Power-down, wake and switching
  a_sleep_entry: assert property (i_power_down_exec && !i_mode.idle_select_bit && o_clk.cpu_clk_en &&
    o_clk.periph_clk_en |=> !o_clk.cpu_clk_en && !o_clk.periph_clk_en && o_clk.mux_sel == SRC_NONE &&
    !o_clk.pri_osc_run && o_status == 2'h0) else $error("sleep entry wrong");
  a_idle_entry: assert property (i_power_down_exec && i_mode.idle_select_bit && o_clk.cpu_clk_en &&
    o_clk.periph_clk_en && i_mode.clock_source_select == o_clk.mux_sel |=> !o_clk.cpu_clk_en &&
    o_clk.periph_clk_en && o_status == $past(o_status)) else $error("idle entry wrong");
  a_idle_wake: assert property (!o_clk.cpu_clk_en && o_clk.periph_clk_en &&
    (i_wake_interrupt || i_wdt_timeout) |=> !o_clk.cpu_clk_en ##[1:DLY_MAX] o_clk.cpu_clk_en)
    else $error("idle wake delay wrong");
  a_gates_before_mux: assert property (o_clk.mux_sel != $past(o_clk.mux_sel) && o_clk.mux_sel != SRC_NONE &&
    !i_mode.two_speed_enabled && !i_mode.fscm_enabled |-> !$past(o_clk.periph_clk_en) &&
    !o_clk.periph_clk_en && !o_clk.cpu_clk_en) else $error("mux moved with gates open");
  a_sec_osc_follow: assert property (!$past(i_reset) |->
    o_clk.sec_osc_run == $past(i_mode.secondary_osc_enable)) else $error("secondary enable not followed");
  a_rc_for_wdt: assert property (i_mode.wdt_enabled |-> ##2 o_clk.rc_osc_run)
    else $error("internal oscillator stopped with watchdog on");
  c_sleep: cover property (i_power_down_exec && !i_mode.idle_select_bit && o_clk.cpu_clk_en);
  c_idle: cover property (i_power_down_exec && i_mode.idle_select_bit && o_clk.cpu_clk_en);
  c_secondary_run: cover property ($rose(o_status.secondary_clock_active_flag));
endmodule : power_mode_clock_switch_control_sva

bind power_mode_clock_switch_control power_mode_clock_switch_control_sva #(
  .CPU_READY_DELAY_NS(CPU_READY_DELAY_NS)
) i_power_mode_clock_switch_control_sva (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_mode(i_mode), .i_power_down_exec(i_power_down_exec),
  .i_wake_interrupt(i_wake_interrupt), .i_wdt_timeout(i_wdt_timeout), .i_osc(i_osc),
  .o_clk(o_clk), .o_status(o_status)
);
`default_nettype wire

// ===== verif/power_mode_clock_switch_control_test.sv
`default_nettype none
module power_mode_clock_switch_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pmcs_pkg::*;
  localparam int CSD_NS = 10;
  localparam int CSD = CSD_NS / SYS_CLK_PERIOD_NS;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  mode_ctrl_s mode = 9'h131; // Primary, secondary and watchdog on
  logic pd = 1'b0;
  logic wake_irq = 1'b0;
  logic wdt_to = 1'b0;
  logic sec_hold = 1'b0;
  logic xtal = 1'b0;
  logic [1:0] cur = SEL_PRI;
  osc_pins_s osc;
  clk_ctrl_s ck;
  status_s st;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 35928;
  int n;

  power_mode_clock_switch_control #(
    .CPU_READY_DELAY_NS(CSD_NS)
  ) i_power_mode_clock_switch_control (
    .i_sys_clk(sys_clk), .i_reset(rst), .i_mode(mode), .i_power_down_exec(pd),
    .i_wake_interrupt(wake_irq), .i_wdt_timeout(wdt_to), .i_osc(osc), .o_clk(ck), .o_status(st)
  );
  osc_source_model i_osc_source_model (.i_ctrl(ck), .i_sec_hold(sec_hold), .o_pins(osc));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  function automatic logic [1:0] exp_flags(input logic [1:0] sel);
    return {sel == SEL_PRI, sel == SEL_SEC};
  endfunction : exp_flags

  function automatic int per_ns(input logic [1:0] s);
    return (s == SEL_PRI) ? 10 : (s == SEL_SEC) ? 41 : 32;
  endfunction : per_ns

  // Bounded wait for CPU running on source m
  task automatic wait_run(input logic [1:0] m, input int lim);
    n = 0;
    while (!(ck.cpu_clk_en === 1'b1 && ck.mux_sel === m)) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > lim) begin
        n_fail++;
        $display("mismatch at %0t: wait ran out, mux %h expected %h", $time, ck.mux_sel, m);
        test_done();
      end
    end
  endtask : wait_run

  task automatic go_run(input logic [1:0] sel);
    @(posedge sys_clk);
    mode.clock_source_select <= sel;
    mode.pri_is_crystal <= xtal;
    wait_run(sel, 6000);
    check(st, exp_flags(sel));
    check({ck.pri_osc_run, ck.rc_osc_run}, {sel == SEL_PRI, 1'b1});
    if (sel != cur && sel != SEL_PRI) begin
      check(n * 5 >= per_ns(cur) + 2 * per_ns(sel) && n * 5 <= 2 * per_ns(cur) + 4 * per_ns(sel) + 60, 1'b1);
    end
    cur = sel;
  endtask : go_run

  task automatic power_down(input logic idle);
    @(posedge sys_clk);
    mode.idle_select_bit <= idle;
    pd <= 1'b1;
    @(posedge sys_clk);
    pd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : power_down

  task automatic wake(input logic by_wdt);
    @(posedge sys_clk);
    wdt_to <= by_wdt;
    wake_irq <= !by_wdt;
    @(posedge sys_clk);
    wdt_to <= 1'b0;
    wake_irq <= 1'b0;
  endtask : wake

  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check({ck.mux_sel, st}, {SRC_PRI, 2'h2});
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      go_run(2'(1 + {$random(seed)} % 3));
    end
    go_run(SEL_RC);
    xtal = 1'b1;
    go_run(SEL_PRI);
    check(n >= 2048, 1'b1);
    xtal = 1'b0;
    $display("test switching done");
    for (int s = 1; s < 4; s++) begin
      go_run(2'(s));
      power_down(1'b1);
      check({ck.cpu_clk_en, ck.periph_clk_en, st}, {2'h1, exp_flags(2'(s))});
      wake(1'($random(seed)));
      wait_run(2'(s), 40);
      check(n + 1 >= CSD && n <= CSD + 4, 1'b1);
      check(st, exp_flags(2'(s)));
      power_down(1'b0);
      check({ck.cpu_clk_en, ck.periph_clk_en, ck.mux_sel, ck.pri_osc_run, st}, 7'h0);
      check({ck.sec_osc_run, ck.rc_osc_run}, 2'h3);
      wake(1'b1);
      wait_run(2'(s), 6000);
      check(st, exp_flags(2'(s)));
    end
    $display("test power-down done");
    go_run(SEL_PRI);
    @(posedge sys_clk);
    mode.secondary_osc_enable <= 1'b0;
    mode.clock_source_select <= SEL_SEC;
    repeat (200) @(posedge sys_clk);
    #1;
    check({ck.mux_sel, st}, {SRC_PRI, 2'h2});
    power_down(1'b1);
    check({ck.cpu_clk_en, ck.mux_sel}, {1'b1, SRC_PRI});
    check(ck.sec_osc_run, 1'b0);
    @(posedge sys_clk);
    mode.secondary_osc_enable <= 1'b1;
    sec_hold <= 1'b1;
    repeat (300) @(posedge sys_clk);
    #1;
    check({ck.cpu_clk_en, st.secondary_clock_active_flag}, 2'h0);
    @(posedge sys_clk);
    sec_hold <= 1'b0;
    wait_run(SEL_SEC, 400);
    check(st, 2'h1);
    cur = SEL_SEC;
    go_run(SEL_PRI);
    $display("test secondary gating done");
    test_done();
  end
endmodule : power_mode_clock_switch_control_test
`default_nettype wire
